/* File: design/gao_output_ctrl.sv */
// Gas alarm output control: threshold or pulse alarm pin, analog duties,
// heater PI loop and serial settings, with a register port and interrupt.
// Assumes measurement, error and temperature inputs are on this clock.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module gao_output_ctrl
    import gao_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic [15:0] concentration,
    input wire logic measValid,
    input wire logic internalError,
    input wire logic [15:0] sensorTemp,
    output logic alarm_pulse_output,
    output logic analog_voltage_output,
    output logic analog_current_output,
    output logic [7:0] heaterDrive,
    output logic [7:0] serialConfig,
    output logic irq
);
    typedef enum logic [1:0] {GAO_HOLD, GAO_RUN, GAO_FAULT} gao_state_t;

    gao_state_t state;
    logic [31:0] ctrl;
    logic [15:0] detection_threshold_limit;
    logic [15:0] hyst;
    logic [15:0] fullScale;
    logic [7:0] voltSpan;
    logic [7:0] currSpan;
    logic [15:0] heatSet;
    logic [15:0] concLatched;
    logic alarmState;
    logic [16:0] pwmCnt;
    logic [16:0] duty;
    logic [16:0] next_duty;
    logic [3:0] irqStat;
    logic [3:0] irqEn;
    logic [3:0] irqSet;
    logic [3:0] irqClr;
    logic [20:0] piInteg;
    logic pwmMode;
    logic running;
    logic [15:0] lowerEdge;

    // Mode and run decode shared by the output and event logic
    assign pwmMode = ctrl[GAO_CTRL_PWM_BIT];
    assign running = (state == GAO_RUN);
    // Saturate so a hysteresis above the limit cannot wrap
    assign lowerEdge = (hyst > detection_threshold_limit) ? 16'h0000 :
                       detection_threshold_limit - hyst;

    // Scale a count against a span, saturating at the top
    function automatic logic [16:0] gao_scale(input logic [15:0] val,
                                              input logic [15:0] span);
        logic [32:0] prod;
        prod = 33'(val) * 33'(GAO_PWM_STEPS);
        if (span == 16'h0000 || val >= span) begin
            gao_scale = GAO_PWM_STEPS;
        end else begin
            gao_scale = 17'(prod / 33'(span));
        end
    endfunction

    // Register hit test, shared by every write decode
    function automatic logic gao_hit(input logic strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
        gao_hit = strobe && (addr == target);
    endfunction

    // Power-up hold, release on first valid sample, error lock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= GAO_HOLD;
        end else begin
            case (state)
                GAO_HOLD: begin
                    if (internalError) begin
                        state <= GAO_FAULT;
                    end else if (measValid) begin
                        state <= GAO_RUN;
                    end
                end
                GAO_RUN: begin
                    if (internalError) begin
                        state <= GAO_FAULT;
                    end
                end
                GAO_FAULT: begin
                    // Leave only once error clears and data is fresh
                    if (!internalError && measValid) begin
                        state <= GAO_RUN;
                    end
                end
                default: state <= GAO_HOLD;
            endcase
        end
    end

    // Latest measurement
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            concLatched <= 16'h0000;
        end else if (measValid) begin
            concLatched <= concentration;
        end
    end

    // Threshold comparator with hysteresis; high means safe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            alarmState <= 1'b1;
        end else if (measValid) begin
            if (concentration > detection_threshold_limit) begin
                alarmState <= 1'b0;
            end else if (concentration < lowerEdge) begin
                alarmState <= 1'b1;
            end
        end
    end

    // Duty target for the current concentration
    always_comb begin
        next_duty = gao_scale(concLatched, fullScale);
    end

    // 1 kHz period counter; duty reloads only at period end to avoid glitches
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pwmCnt <= 17'h00000;
            duty <= 17'h00000;
        end else if (pwmCnt == GAO_PWM_LAST) begin
            pwmCnt <= 17'h00000;
            duty <= next_duty;
        end else begin
            pwmCnt <= pwmCnt + 17'h00001;
        end
    end

    // Output pins; three outputs share one source, host wires only one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            alarm_pulse_output <= 1'b0;
            analog_voltage_output <= 1'b0;
            analog_current_output <= 1'b0;
        end else if (!running) begin
            alarm_pulse_output <= 1'b0;
            analog_voltage_output <= 1'b0;
            analog_current_output <= 1'b0;
        end else begin
            alarm_pulse_output <= pwmMode ? (pwmCnt < duty) : alarmState;
            // Analog variants follow the pulse path, scaled by span
            analog_voltage_output <= pwmMode &&
                (pwmCnt < gao_scale({8'h00, concLatched[15:8]},
                 {8'h00, voltSpan}));
            analog_current_output <= pwmMode &&
                (pwmCnt < gao_scale({8'h00, concLatched[15:8]},
                 {8'h00, currSpan}));
        end
    end

    // Heater PI loop; output held off when disabled to save power
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            piInteg <= 21'h000000;
            heaterDrive <= 8'h00;
        end else if (!ctrl[GAO_CTRL_HEAT_EN_BIT]) begin
            piInteg <= 21'h000000;
            heaterDrive <= 8'h00;
        end else begin : pi
            logic signed [20:0] err;
            logic signed [21:0] sum;
            err = 21'($signed({1'b0, heatSet}) - $signed({1'b0, sensorTemp}));
            // Clamp the integrator at zero: heaters cannot cool
            // Hold at the top only while the error still pushes up,
            // so a falling error can always unwind a saturated sum
            if ($signed(piInteg) + err < 0) begin
                piInteg <= 21'h000000;
            end else if (piInteg[20:19] == 2'b01 && !err[20]) begin
                piInteg <= piInteg;
            end else begin
                piInteg <= 21'($signed(piInteg) + err);
            end
            sum = 22'(err >>> GAO_KP_SHIFT) +
                  22'($signed(piInteg) >>> GAO_KI_SHIFT);
            if (sum < 0) begin
                heaterDrive <= 8'h00;
            end else if (sum > 22'sd255) begin
                heaterDrive <= 8'hFF;
            end else begin
                heaterDrive <= sum[7:0];
            end
        end
    end

    // Mode bit and heater enable; upper bits read back as zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= GAO_CTRL_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_CTRL)) begin
            ctrl <= {30'h0, regWrData[1:0]};
        end
    end

    // Alarm limit; still writable, so a product that must lock it
    // has to keep this write port away from field users
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            detection_threshold_limit <= GAO_THRESH_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_THRESH)) begin
            detection_threshold_limit <= regWrData[15:0];
        end
    end

    // Hysteresis width; a value above the limit saturates the band
    // edge at zero rather than wrapping
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hyst <= GAO_HYST_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_HYST)) begin
            hyst <= regWrData[15:0];
        end
    end

    // Full-scale concentration for pulse mode; zero means always full
    // duty, which is safer than a divide by zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fullScale <= GAO_FULLSCALE_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_FULLSCALE)) begin
            fullScale <= regWrData[15:0];
        end
    end

    // Voltage variant span
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            voltSpan <= GAO_VSPAN_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_VSPAN)) begin
            voltSpan <= regWrData[7:0];
        end
    end

    // Current variant span
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            currSpan <= GAO_ISPAN_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_ISPAN)) begin
            currSpan <= regWrData[7:0];
        end
    end

    // Heater setpoint; a change takes effect on the next loop step
    // without resetting the integrator, so only the proportional part of the drive steps
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            heatSet <= GAO_HEATSET_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_HEATSET)) begin
            heatSet <= regWrData[15:0];
        end
    end

    // Serial settings are only stored; the link itself lives outside
    // this block and must pick up a change at a frame boundary
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serialConfig <= GAO_SERIAL_RST;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_SERIAL)) begin
            serialConfig <= regWrData[7:0];
        end
    end

    // Interrupt mask; status bits latch whether masked or not, so
    // unmasking later still reports events that already happened
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqEn <= 4'h0;
        end else if (gao_hit(regWrite, regAddr, GAO_REG_IRQ_EN)) begin
            irqEn <= regWrData[3:0];
        end
    end

    // Events: alarm entry, alarm exit, error, first release
    always_comb begin
        irqSet = 4'h0;
        irqSet[GAO_IRQ_ALARM] = running && !pwmMode && alarmState &&
            measValid && concentration > detection_threshold_limit;
        irqSet[GAO_IRQ_CLEAR] = running && !pwmMode && !alarmState &&
            measValid && concentration < lowerEdge;
        irqSet[GAO_IRQ_ERROR] = internalError && state != GAO_FAULT;
        irqSet[GAO_IRQ_VALID] = state == GAO_HOLD && measValid &&
            !internalError;
        irqClr = gao_hit(regWrite, regAddr, GAO_REG_IRQ_CLR) ?
            regWrData[3:0] : 4'h0;
    end

    // Sticky status; a set in the clear cycle wins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqStat <= 4'h0;
        end else begin
            irqStat <= (irqStat & ~irqClr) | irqSet;
        end
    end

    // Level interrupt, registered so the pin never glitches
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irqStat & ~irqClr) | irqSet) & irqEn);
        end
    end

    // Read port, data in the cycle after the strobe only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                GAO_REG_CTRL: regRdData <= ctrl;
                GAO_REG_THRESH: regRdData <= {16'h0, detection_threshold_limit};
                GAO_REG_HYST: regRdData <= {16'h0, hyst};
                GAO_REG_FULLSCALE: regRdData <= {16'h0, fullScale};
                GAO_REG_VSPAN: regRdData <= {24'h0, voltSpan};
                GAO_REG_ISPAN: regRdData <= {24'h0, currSpan};
                GAO_REG_HEATSET: regRdData <= {16'h0, heatSet};
                GAO_REG_SERIAL: regRdData <= {24'h0, serialConfig};
                GAO_REG_STATUS: regRdData <= {20'h0, heaterDrive,
                    1'b0, alarmState, 2'(state)};
                GAO_REG_IRQ_STAT: regRdData <= {28'h0, irqStat};
                GAO_REG_IRQ_EN: regRdData <= {28'h0, irqEn};
                GAO_REG_CONC: regRdData <= {16'h0, concLatched};
                default: regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end
endmodule // gao_output_ctrl

/* File: shared/gao_pkg.sv */
// Constants, register map and field layout of the gas alarm output block.
// Assumes concentration arrives as a 16-bit count, 100 counts per %LOWER_FLAMMABLE_LIMIT.
// What this block does
// - Threshold mode: alarm pin low above the detection limit, high again below the limit less hysteresis.
// - Reset config: detection limit 10% and hysteresis 5% of LOWER_FLAMMABLE_LIMIT.
// - Pin, voltage and current outputs held at zero while no measurement exists after power-up.
// - First valid measurement releases outputs at once to follow concentration.
// - Internal error forces the pin and voltage output to zero.
// - Internal error forces the current output to zero.
// - Pulse-width mode: duty proportional to concentration.
// - Pulse train repeats at a fixed 1 kHz.
// - Voltage variant uses pulse mode; voltage span and range are configurable.
// - Current variant uses pulse mode; current span and range are configurable.
// - Heaters run from a PI loop toward a setpoint, default +25 C.
// - Serial bit rate, parity and stop bits are configurable.
// - No warm-up: the first measurement is already valid for outputs.
package gao_pkg;
    // Register byte addresses, address = index * 4
    localparam logic [7:0] GAO_REG_CTRL = 8'h00;
    localparam logic [7:0] GAO_REG_THRESH = 8'h04;
    localparam logic [7:0] GAO_REG_HYST = 8'h08;
    localparam logic [7:0] GAO_REG_FULLSCALE = 8'h0C;
    localparam logic [7:0] GAO_REG_VSPAN = 8'h10;
    localparam logic [7:0] GAO_REG_ISPAN = 8'h14;
    localparam logic [7:0] GAO_REG_HEATSET = 8'h18;
    localparam logic [7:0] GAO_REG_SERIAL = 8'h1C;
    localparam logic [7:0] GAO_REG_STATUS = 8'h20;
    localparam logic [7:0] GAO_REG_IRQ_STAT = 8'h24;
    localparam logic [7:0] GAO_REG_IRQ_EN = 8'h28;
    localparam logic [7:0] GAO_REG_IRQ_CLR = 8'h2C;
    localparam logic [7:0] GAO_REG_CONC = 8'h30;
    // Control fields
    localparam int GAO_CTRL_PWM_BIT = 0;
    localparam int GAO_CTRL_HEAT_EN_BIT = 1;
    // Concentration scale: 100 counts per %LOWER_FLAMMABLE_LIMIT
    localparam logic [15:0] GAO_THRESH_RST = 16'h03E8; // 10 %LOWER_FLAMMABLE_LIMIT
    localparam logic [15:0] GAO_HYST_RST = 16'h01F4; // 5 %LOWER_FLAMMABLE_LIMIT
    localparam logic [15:0] GAO_FULLSCALE_RST = 16'h2710; // 100 %LOWER_FLAMMABLE_LIMIT
    localparam logic [7:0] GAO_VSPAN_RST = 8'hFF;
    localparam logic [7:0] GAO_ISPAN_RST = 8'hFF;
    localparam logic [15:0] GAO_HEATSET_RST = 16'h0FA0; // +25.00 C, 1/160 C
    localparam logic [7:0] GAO_SERIAL_RST = 8'h03; // rate 3, no parity, 1 stop
    localparam logic [31:0] GAO_CTRL_RST = 32'h0000_0002;
    // Pulse timing
    localparam int GAO_CLK_HZ = 100_000_000;
    localparam int GAO_PWM_HZ = 1_000;
    localparam int GAO_PWM_CYC = GAO_CLK_HZ / GAO_PWM_HZ;
    localparam logic [16:0] GAO_PWM_LAST = 17'(GAO_PWM_CYC - 1);
    localparam logic [16:0] GAO_PWM_STEPS = 17'(GAO_PWM_CYC);
    // PI gains as right shifts
    localparam int GAO_KP_SHIFT = 4;
    localparam int GAO_KI_SHIFT = 8;
    // Interrupt bits
    localparam int GAO_IRQ_ALARM = 0;
    localparam int GAO_IRQ_CLEAR = 1;
    localparam int GAO_IRQ_ERROR = 2;
    localparam int GAO_IRQ_VALID = 3;
endpackage

/* File: verif/gao_host_model.sv */
// Host model: watches the alarm pin only and times each high pulse.
// Assumes the pin is sampled on the block's own clock.
`timescale 1ns/1ps
module gao_host_model (
    input wire logic clock,
    input wire logic alarmPin,
    output logic [31:0] highWidth,
    output logic [31:0] pulseCount
);
    logic [31:0] run;
    initial begin
        run = 32'h0;
        highWidth = 32'h0;
        pulseCount = 32'h0;
    end
    // Only the one pin is wired; the other two are left open
    always @(posedge clock) begin
        if (alarmPin === 1'b1) begin
            run <= run + 32'h1;
        end else if (run != 32'h0) begin
            highWidth <= run;
            pulseCount <= pulseCount + 32'h1;
            run <= 32'h0;
        end
    end
endmodule // gao_host_model

/* File: verif/gao_output_ctrl_bench.sv */
// Self-checking bench for the gas alarm output block.
// Assumes the host model watches the alarm pin; pulse test runs ~100k cycles.
`timescale 1ns/1ps
module gao_output_ctrl_bench
    import gao_pkg::*;
;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] concentration = 16'h0000;
    logic measValid = 1'b0;
    logic internalError = 1'b0;
    logic [15:0] sensorTemp = 16'h0000;
    logic [31:0] regRdData, got, highWidth, pulseCount, n0;
    logic alarmPin, voltOut, currOut, irq;
    logic [7:0] heaterDrive, serialConfig;
    int error_cnt = 0;
    int cmp_count = 0;
    int vHigh = 0;
    int iHigh = 0;
    int cycles = 0;
    // Rows: concentration in, expected pin; boundaries of limit and band
    logic [15:0] rowConc [7] = '{16'h0000, 16'h03E9, 16'h03E8, 16'h01F4,
        16'h01F3, 16'h03E8, 16'h03E9};
    logic rowPin [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0] resAddr [10] = '{GAO_REG_CTRL, GAO_REG_THRESH, GAO_REG_HYST,
        GAO_REG_FULLSCALE, GAO_REG_VSPAN, GAO_REG_ISPAN, GAO_REG_HEATSET,
        GAO_REG_SERIAL, GAO_REG_IRQ_EN, GAO_REG_IRQ_CLR};
    logic [31:0] resVal [10] = '{GAO_CTRL_RST, 32'(GAO_THRESH_RST),
        32'(GAO_HYST_RST), 32'(GAO_FULLSCALE_RST), 32'(GAO_VSPAN_RST),
        32'(GAO_ISPAN_RST), 32'(GAO_HEATSET_RST), 32'(GAO_SERIAL_RST),
        32'h0, 32'h0};
    gao_output_ctrl dut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .concentration(concentration),
        .measValid(measValid), .internalError(internalError),
        .sensorTemp(sensorTemp), .alarm_pulse_output(alarmPin),
        .analog_voltage_output(voltOut), .analog_current_output(currOut),
        .heaterDrive(heaterDrive), .serialConfig(serialConfig), .irq(irq));
    gao_host_model u_host (.clock(clock), .alarmPin(alarmPin),
        .highWidth(highWidth), .pulseCount(pulseCount));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string m);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        d = regRdData;
    endtask
    // Output follows two cycles after the sample; wait a little longer
    task automatic meas(input logic [15:0] c);
        @(posedge clock);
        concentration <= c;
        measValid <= 1'b1;
        @(posedge clock);
        measValid <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard sized for one full pulse period plus margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 130000) begin
            error_cnt++;
            $display("[FAIL] t=%0t timeout", $time);
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        repeat (20) @(negedge clock);
        chk({alarmPin, voltOut, currOut}, 0, "hold");
        for (int i = 0; i < 10; i++) begin
            rd(resAddr[i], got);
            chk(got, resVal[i], "reset value");
        end
        wr(GAO_REG_IRQ_EN, 32'hF);
        for (int i = 0; i < 7; i++) begin
            meas(rowConc[i]);
            chk(alarmPin, rowPin[i], "threshold");
        end
        rd(GAO_REG_IRQ_STAT, got);
        chk({got[3:0], irq}, 5'h17, "irq events");
        wr(GAO_REG_IRQ_CLR, 32'hF);
        repeat (3) @(negedge clock);
        rd(GAO_REG_IRQ_STAT, got);
        chk({got[3:0], irq}, 5'h00, "irq clear");
        // Error with its interrupt masked, then unmasked
        wr(GAO_REG_IRQ_EN, 32'h0);
        internalError <= 1'b1;
        repeat (6) @(negedge clock);
        rd(GAO_REG_STATUS, got);
        chk({got[1:0], alarmPin, voltOut, currOut, irq}, 6'h20,
            "fault");
        wr(GAO_REG_IRQ_EN, 32'h4);
        repeat (3) @(negedge clock);
        chk(irq, 1'b1, "irq unmask");
        @(posedge clock);
        internalError <= 1'b0;
        meas(16'h0000);
        chk(alarmPin, 1'b1, "fault exit");
        chk(heaterDrive != 8'h00, 1'b1, "heater");
        wr(GAO_REG_SERIAL, 32'h5A);
        repeat (3) @(negedge clock);
        chk(serialConfig, 8'h5A, "serial");
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, got);
        chk(got, 32'h0, "unmapped");
        // Mid-run reset: back to hold with defaults, then first sample
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock);
        chk({alarmPin, voltOut, currOut, irq}, 0, "reboot hold");
        rd(GAO_REG_SERIAL, got);
        chk(got, 32'(GAO_SERIAL_RST), "reboot config");
        meas(16'h0000);
        chk(alarmPin, 1'b1, "first sample");
        // Pulse mode: 0x100 of 0x2710 full scale is 2560 of 100000 cycles;
        // analog high byte 1 gives 100000/255 and 100000/128 cycles
        wr(GAO_REG_ISPAN, 32'h80);
        wr(GAO_REG_CTRL, 32'h3);
        meas(16'h0100);
        n0 = pulseCount;
        for (int w = 0; w < 105000 && pulseCount == n0; w++) begin
            @(negedge clock);
            if (alarmPin && voltOut) vHigh++;
            if (alarmPin && currOut) iHigh++;
        end
        @(negedge clock);
        chk(highWidth, 32'd2560, "pulse width");
        chk(vHigh, 32'd392, "voltage duty");
        chk(iHigh, 32'd781, "current duty");
        finish_test();
    end
endmodule // gao_output_ctrl_bench

/* File: verif/gao_output_ctrl_chk.sv */
// Checker: alarm levels, hold and fault zeroing, register read rules.
// Assumes config changes arrive only through the register write port.
`timescale 1ns/1ps
module gao_output_ctrl_chk
    import gao_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    input wire logic [15:0] concentration,
    input wire logic measValid,
    input wire logic internalError,
    input wire logic alarm_pulse_output,
    input wire logic analog_voltage_output,
    input wire logic analog_current_output
);
    logic [15:0] thr;
    logic [15:0] hyst;
    logic pwm;
    logic seen;
    logic flt;
    // Shadow of the config, so limits follow software writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            thr <= GAO_THRESH_RST;
            hyst <= GAO_HYST_RST;
            pwm <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == GAO_REG_THRESH) thr <= regWrData[15:0];
            if (regAddr == GAO_REG_HYST) hyst <= regWrData[15:0];
            if (regAddr == GAO_REG_CTRL) pwm <= regWrData[GAO_CTRL_PWM_BIT];
        end
    end
    // Valid sample seen; fault pending keeps the old level unknown
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            seen <= 1'b0;
            flt <= 1'b0;
        end else begin
            if (measValid && !internalError) seen <= 1'b1;
            if (internalError) flt <= 1'b1;
            else if (measValid) flt <= 1'b0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_alarm_above: assert property (
        measValid && !internalError && !pwm && concentration > thr
        |-> ##[1:3] !alarm_pulse_output) else $error("pin high above limit");
    a_alarm_below: assert property (
        measValid && !internalError && !pwm && concentration < thr - hyst
        |-> ##[1:3] alarm_pulse_output) else $error("pin low below band");
    a_band_keeps_low: assert property (
        measValid && !internalError && !pwm && seen && !flt
        && !alarm_pulse_output && concentration >= thr - hyst
        |=> !alarm_pulse_output [*3]) else $error("pin rose inside band");
    a_high_stays_high: assert property (
        measValid && !internalError && !pwm && alarm_pulse_output
        && concentration <= thr |=> alarm_pulse_output [*3])
        else $error("pin fell at or below limit");
    a_hold_zero: assert property (
        !seen |-> !alarm_pulse_output && !analog_voltage_output
        && !analog_current_output) else $error("output left hold early");
    a_error_zero: assert property (
        internalError [*3] |=> !alarm_pulse_output && !analog_voltage_output
        && !analog_current_output) else $error("output not zero in error");
    a_analog_idle: assert property (
        !pwm [*4] |-> !analog_voltage_output && !analog_current_output)
        else $error("analog output active in threshold mode");
    a_read_idle: assert property (
        !$past(regRead) |-> regRdData == 32'h0)
        else $error("read data outside read cycle");
    a_unmapped_read: assert property (
        regRead && regAddr > GAO_REG_CONC |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
endmodule // gao_output_ctrl_chk

bind gao_output_ctrl gao_output_ctrl_chk u_chk (.clock(clock),
    .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .concentration(concentration), .measValid(measValid),
    .internalError(internalError), .alarm_pulse_output(alarm_pulse_output),
    .analog_voltage_output(analog_voltage_output),
    .analog_current_output(analog_current_output));
